// >>> logic/hdi_pkg.sv
package hdi_pkg;
    localparam logic [7:0] HDI_ADDR_WR_LOW  = 8'h76;
    localparam logic [7:0] HDI_ADDR_WR_HIGH = 8'h78;
    localparam int HDI_IMP_W = 12;
    localparam logic [11:0] HDI_MIC_MIN_OHM = 12'h258;
    localparam logic [11:0] HDI_MIC_MAX_OHM = 12'hBB8;
    localparam logic [11:0] HDI_SPK_MIN_OHM = 12'h010;
    localparam logic [11:0] HDI_SPK_MAX_OHM = 12'h5DC;
    localparam int HDI_CTL3_LAUNCH_BIT = 0;
    localparam int HDI_CTL3_IRQ_BIT    = 2;
    localparam int HDI_CTL3_DIS_BIT    = 3;
    localparam int HDI_CTL3_FORCE_BIT  = 4;
    localparam logic [7:0] HDI_CTL3_RESET = 8'h00;
    localparam int HDI_DET_TIME_MS  = 500;
    localparam int HDI_CLK_MHZ      = 100;
    localparam int HDI_DET_CYCLES   = HDI_DET_TIME_MS * 1000 * HDI_CLK_MHZ;
    localparam logic [1:0] HDI_POL_NONE   = 2'b00;
    localparam logic [1:0] HDI_POL_RING2  = 2'b01;
    localparam logic [1:0] HDI_POL_SLEEVE = 2'b10;
    typedef enum logic [1:0] {
        HDI_IDLE    = 2'b00,
        HDI_MEASURE = 2'b01,
        HDI_DONE    = 2'b10
    } hdi_state_t;
endpackage

// >>> logic/hdi_classify.sv
`timescale 1ns/1ps
module hdi_classify
    import hdi_pkg::*;
(
    input  wire logic [HDI_IMP_W-1:0] ring2_ohm,   // ring2 impedance to ground
    input  wire logic [HDI_IMP_W-1:0] sleeve_ohm,  // sleeve impedance to ground
    output logic                      mic_found,   // a mic contact exists
    output logic [1:0]                polarity     // which contact is the mic
);
    logic ring2_mic;
    logic sleeve_mic;
    assign ring2_mic  = (ring2_ohm >= HDI_MIC_MIN_OHM) && (ring2_ohm <= HDI_MIC_MAX_OHM);
    assign sleeve_mic = (sleeve_ohm >= HDI_MIC_MIN_OHM) && (sleeve_ohm <= HDI_MIC_MAX_OHM);
    assign mic_found  = ring2_mic | sleeve_mic;
    // pick mic contact; ring2 preferred when both qualify
    assign polarity = ring2_mic ? HDI_POL_RING2 : (sleeve_mic ? HDI_POL_SLEEVE : HDI_POL_NONE);
endmodule

// >>> logic/hdi_detect_ctrl.sv
`timescale 1ns/1ps
module hdi_detect_ctrl
    import hdi_pkg::*;
#(
    parameter int DET_CYCLES = HDI_DET_CYCLES
) (
    input  wire logic                 sys_clk,        // 100 MHz clock
    input  wire logic                 sys_rst,        // async reset, high
    input  wire logic                 addr_strap,     // address-select strap
    input  wire logic                 detect_launch,  // launch pin
    input  wire logic [7:0]           third_control_reg, // host control byte
    input  wire logic                 ctl_wr,         // pulse: control byte written
    input  wire logic                 indicator_off,  // disable indicator pin; force bit overrides
    input  wire logic [7:0]           addr_byte,      // received address byte
    input  wire logic                 addr_valid,     // pulse: address byte complete
    input  wire logic                 irq_clear,      // pulse: host read results
    input  wire logic [HDI_IMP_W-1:0] ring2_ohm,      // measured ring2 impedance
    input  wire logic [HDI_IMP_W-1:0] sleeve_ohm,     // measured sleeve impedance
    output logic                      addr_ack_r,     // acknowledge address byte
    output logic                      addr_read_r,    // acked transfer is a read
    output logic                      mic_present_r,  // mic-present flag
    output logic [1:0]                polarity_r,     // mic contact result
    output logic                      busy_r,         // detection running
    output logic                      det_done_r,     // pulse: detection finished
    output logic                      ind_o_r,        // indicator pin out (always 0)
    output logic                      ind_oe_r        // indicator pull-low enable
);
    import hdi_pkg::*;

    localparam int CNT_W = $clog2(DET_CYCLES + 1);

    // a zero-length run would leave the counter with nothing to count down
    if (DET_CYCLES < 1) begin : g_bad_det_cycles
        $error("DET_CYCLES must be at least 1");
    end

    hdi_state_t             state_r;
    logic [CNT_W-1:0]       cnt_r;
    logic                   launch_d_r;
    logic                   strap_r;
    logic                   strap_taken_r;
    logic                   irq_pend_r;
    logic                   host_launch;
    logic                   pin_launch;
    logic                   start;
    logic                   mic_found;
    logic [1:0]             polarity;
    logic [7:0]             own_wr;
    logic                   gen_call;
    logic                   own_match;
    logic                   ind_low_nxt;

    hdi_classify hdi_classify_i (
        .ring2_ohm  (ring2_ohm),
        .sleeve_ohm (sleeve_ohm),
        .mic_found  (mic_found),
        .polarity   (polarity)
    );

    // strap caught by a clocked process after reset release
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_r       <= 1'b0;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_r       <= addr_strap;
            strap_taken_r <= 1'b1;
        end
    end

    assign own_wr = strap_r ? HDI_ADDR_WR_HIGH : HDI_ADDR_WR_LOW;

    // seven zero address bits form the general call; kept out explicitly so that
    // a strap encoding change can never make it match by accident
    assign gen_call  = (addr_byte[7:1] == 7'h00);

    // only own address acked, general call ignored
    assign own_match = addr_valid && !gen_call && (addr_byte[7:1] == own_wr[7:1]);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_ack_r  <= 1'b0;
            addr_read_r <= 1'b0;
        end else begin
            addr_ack_r  <= own_match;
            addr_read_r <= own_match && addr_byte[0];
        end
    end

    // either launch source starts a sequence
    assign host_launch = ctl_wr && third_control_reg[HDI_CTL3_LAUNCH_BIT];
    assign pin_launch  = detect_launch && !launch_d_r;
    assign start       = host_launch | pin_launch;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            launch_d_r <= 1'b0;
        end else begin
            launch_d_r <= detect_launch;
        end
    end

    // launches during a running sequence are dropped, not queued
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= HDI_IDLE;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                HDI_IDLE: begin
                    if (start) begin
                        state_r <= HDI_MEASURE;
                        cnt_r   <= CNT_W'(DET_CYCLES - 1);
                    end
                end
                HDI_MEASURE: begin
                    if (cnt_r == '0) begin
                        state_r <= HDI_DONE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                HDI_DONE: begin
                    // one cycle here lets results, pending flag and pulse latch together;
                    // a launch seen in this cycle is dropped like any mid-run launch
                    state_r <= HDI_IDLE;
                end
                default: begin
                    state_r <= HDI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r     <= 1'b0;
            det_done_r <= 1'b0;
        end else begin
            busy_r     <= (state_r == HDI_MEASURE) || (state_r == HDI_IDLE && start);
            det_done_r <= (state_r == HDI_DONE);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mic_present_r <= 1'b0;
            polarity_r    <= HDI_POL_NONE;
        end else if (state_r == HDI_DONE) begin
            mic_present_r <= mic_found;
            polarity_r    <= polarity;
        end
    end

    // update pending until host clears; a new update wins over clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_pend_r <= 1'b0;
        end else if (state_r == HDI_DONE) begin
            irq_pend_r <= 1'b1;
        end else if (irq_clear) begin
            irq_pend_r <= 1'b0;
        end
    end

    always_comb begin
        ind_low_nxt = 1'b0;
        if (third_control_reg[HDI_CTL3_FORCE_BIT]) begin
            ind_low_nxt = 1'b1;
        end else if (indicator_off) begin
            ind_low_nxt = 1'b0;
        end else if (third_control_reg[HDI_CTL3_IRQ_BIT]) begin
            ind_low_nxt = irq_pend_r;
        end else begin
            ind_low_nxt = mic_present_r;
        end
    end

    // open drain: data stays low, never driven high
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ind_o_r <= 1'b0;
        end else begin
            ind_o_r <= 1'b0;
        end
    end

    // enable alone pulls low; released line rises on the pull-up
    // registered so the pin never glitches while mode bits change
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ind_oe_r <= 1'b0;
        end else begin
            ind_oe_r <= ind_low_nxt;
        end
    end
endmodule

// >>> verification/hdi_detect_chk.sv
`timescale 1ns/1ps
module hdi_detect_chk
    import hdi_pkg::*;
#(
    parameter int DET_CYCLES = HDI_DET_CYCLES
) (
    input wire logic       sys_clk,           // clock
    input wire logic       sys_rst,           // reset
    input wire logic       addr_strap,        // strap
    input wire logic       detect_launch,     // pin
    input wire logic [7:0] third_control_reg, // control
    input wire logic       ctl_wr,            // write
    input wire logic       indicator_off,     // off
    input wire logic [7:0] addr_byte,         // byte
    input wire logic       addr_valid,        // byte strobe
    input wire logic       addr_ack_r,        // ack
    input wire logic       addr_read_r,       // read
    input wire logic       mic_present_r,     // flag
    input wire logic [1:0] polarity_r,        // contact
    input wire logic       busy_r,            // busy
    input wire logic       det_done_r,        // done
    input wire logic       ind_o_r,           // pin out
    input wire logic       ind_oe_r           // pin enable
);
    logic [7:0] own;
    int         cnt_r;
    logic       idle;
    assign own = addr_strap ? HDI_ADDR_WR_HIGH : HDI_ADDR_WR_LOW;
    assign idle = !busy_r && !det_done_r;
    // busy length counted here; a repetition of this size would unroll badly
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) cnt_r <= 0;
        else cnt_r <= busy_r ? cnt_r + 1 : 0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_own_ack: assert property (addr_valid && addr_byte[7:1] == own[7:1]
        |=> addr_ack_r && addr_read_r == $past(addr_byte[0])) else $error("own address missed");
    a_foreign_nak: assert property (addr_valid && addr_byte[7:1] != own[7:1]
        |=> !addr_ack_r) else $error("foreign address acked");
    a_pin_start: assert property ($rose(detect_launch) && idle && !$past(busy_r)
        |=> busy_r) else $error("pin launch lost");
    a_host_start: assert property (ctl_wr && third_control_reg[HDI_CTL3_LAUNCH_BIT]
        && idle && !$past(busy_r) |=> busy_r) else $error("host launch lost");
    a_run_length: assert property ($fell(busy_r) |-> cnt_r == DET_CYCLES + 1 && det_done_r)
        else $error("run length wrong");
    a_irq_flag: assert property (det_done_r && third_control_reg[HDI_CTL3_IRQ_BIT]
        && !third_control_reg[HDI_CTL3_FORCE_BIT] && !indicator_off |=> ind_oe_r)
        else $error("update not signalled");
    a_result_hold: assert property (!det_done_r |-> $stable(mic_present_r)
        && $stable(polarity_r)) else $error("result moved mid run");
    a_force_low: assert property (third_control_reg[HDI_CTL3_FORCE_BIT] |=> ind_oe_r)
        else $error("force low ignored");
    a_off_release: assert property (!third_control_reg[HDI_CTL3_FORCE_BIT]
        && indicator_off |=> !ind_oe_r) else $error("disabled pin pulls");
    a_mic_level: assert property (!third_control_reg[HDI_CTL3_FORCE_BIT] && !indicator_off
        && !third_control_reg[HDI_CTL3_IRQ_BIT] |=> ind_oe_r == $past(mic_present_r))
        else $error("pin not following flag");
    a_drain_only: assert property (ind_o_r == 1'b0) else $error("pin driven high");
    cover property (addr_ack_r && addr_read_r);
    cover property (det_done_r && mic_present_r);
    cover property (det_done_r && polarity_r == HDI_POL_SLEEVE);
endmodule

// >>> verification/hdi_host_model.sv
`timescale 1ns/1ps
module hdi_host_model (
    input  wire logic       sys_clk,    // device clock
    input  wire logic       send,       // bench asks for one address byte
    input  wire logic [7:0] tx,         // byte to send
    output logic [7:0]      addr_byte,  // byte assembled off the wire
    output logic            addr_valid  // one-cycle byte strobe
);
    initial addr_byte = 8'h00;
    initial addr_valid = 1'b0;
    // between bytes nothing is valid, so show the inverse instead of a stale copy
    always @(posedge sys_clk) begin
        addr_valid <= send;
        addr_byte <= send ? tx : ~addr_byte;
    end
endmodule

// >>> verification/headset_detect_indicator_bench.sv
`timescale 1ns/1ps
module headset_detect_indicator_bench;
    import hdi_pkg::*;
    localparam int DC = 20;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, strap = 1'b0, launch = 1'b0;
    logic        ctl_wr = 1'b0, off = 1'b0, clr = 1'b0, send = 1'b0;
    logic [7:0]  ctl = HDI_CTL3_RESET, tx = 8'h00, ab;
    logic [11:0] r2 = 12'h000, sl = 12'h000;
    logic        av, ack, rd, mic, busy, done, io, oe;
    logic [1:0]  pol;
    int          n_mismatch = 0, samples_checked = 0;
    always #5 sys_clk = ~sys_clk;
    hdi_host_model hdi_host_model_i (.sys_clk(sys_clk), .send(send), .tx(tx), .addr_byte(ab),
        .addr_valid(av));
    hdi_detect_ctrl #(.DET_CYCLES(DC)) hdi_detect_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .addr_strap(strap), .detect_launch(launch), .third_control_reg(ctl), .ctl_wr(ctl_wr),
        .indicator_off(off), .addr_byte(ab), .addr_valid(av), .irq_clear(clr), .ring2_ohm(r2),
        .sleeve_ohm(sl), .addr_ack_r(ack), .addr_read_r(rd), .mic_present_r(mic),
        .polarity_r(pol), .busy_r(busy), .det_done_r(done), .ind_o_r(io), .ind_oe_r(oe));
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic rst(input logic s);
        sys_rst = 1'b1;
        strap = s;
        tick(12);
        sys_rst = 1'b0;
        tick(2);
    endtask
    task automatic addr(input logic [7:0] b, input logic a, input logic r);
        tx = b;
        send = 1'b1;
        tick(1);
        send = 1'b0;
        tick(1);
        chk({6'h00, rd, ack}, {6'h00, r, a});
    endtask
    // a second launch mid run must not restart the count
    task automatic det(input logic pin, input logic [11:0] a, b, input logic [2:0] exp);
        int i;
        // contacts stay quiet and steady for the whole run
        r2 = a;
        sl = b;
        launch = pin;
        ctl_wr = !pin;
        ctl[HDI_CTL3_LAUNCH_BIT] = !pin;
        tick(1);
        launch = 1'b0;
        ctl_wr = 1'b0;
        ctl[HDI_CTL3_LAUNCH_BIT] = 1'b0;
        chk({7'h00, busy}, 8'h01);
        for (i = 1; i < 100 && done !== 1'b1; i++) begin
            launch = (i == 5);
            tick(1);
        end
        if (done !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t detection never finished", $time);
            end_of_test();
        end
        chk(8'(i), 8'(DC + 2));
        chk({5'h00, mic, pol}, {5'h00, exp});
        tick(1);
    endtask
    task automatic t_address();
        addr(8'h76, 1'b1, 1'b0);
        addr(8'h77, 1'b1, 1'b1);
        addr(8'h78, 1'b0, 1'b0);
        addr(8'h00, 1'b0, 1'b0);
        $display("address test over");
    endtask
    task automatic t_detect();
        det(1'b1, 12'd1000, 12'd10, {1'b1, HDI_POL_RING2});
        chk({io, oe}, 8'h01);
        det(1'b0, 12'd20, 12'd2000, {1'b1, HDI_POL_SLEEVE});
        det(1'b1, 12'd3001, 12'd599, {1'b0, HDI_POL_NONE});
        chk({7'h00, oe}, 8'h00);
        det(1'b0, 12'd600, 12'd3000, {1'b1, HDI_POL_RING2});
        $display("detect test over");
    endtask
    task automatic t_modes();
        ctl[HDI_CTL3_IRQ_BIT] = 1'b1;
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(1);
        chk({7'h00, oe}, 8'h00);
        det(1'b1, 12'd1000, 12'd10, {1'b1, HDI_POL_RING2});
        chk({7'h00, oe}, 8'h01);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(1);
        chk({7'h00, oe}, 8'h00);
        ctl = 8'h10;
        tick(2);
        chk({7'h00, oe}, 8'h01);
        ctl = 8'h00;
        off = 1'b1;
        tick(2);
        chk({7'h00, oe}, 8'h00);
        off = 1'b0;
        tick(2);
        chk({7'h00, oe}, 8'h01);
        $display("mode test over");
    endtask
    task automatic t_strap();
        rst(1'b1);
        addr(8'h79, 1'b1, 1'b1);
        addr(8'h76, 1'b0, 1'b0);
        $display("strap test over");
    endtask
    initial begin
        rst(1'b0);
        t_address();
        t_detect();
        t_modes();
        t_strap();
        end_of_test();
    end
endmodule
bind hdi_detect_ctrl hdi_detect_chk #(.DET_CYCLES(DET_CYCLES)) hdi_detect_chk_i (.*);
